//--- verilog/srl_top.sv
// SR latch with comparator output path behind an AHB-Lite register slave
// What this block does
// - Latch and both its pins work only while latch_enable is 1.
// - Divider makes one-cycle pulse every 4..512 cycles per pulse_divider_select.
// - True output pin shows latch state when enabled, true_output_enable set and its direction bit at output.
// - Inverted output pin shows complement when enabled, inverted_output_enable set and its direction bit at output.
// - Writing soft_set_pulse 1 sets latch for one Q-clock period.
// - Writing soft_reset_pulse 1 resets latch for one Q-clock period.
// - Both soft pulse bits clear themselves and always read 0.
// - pin_set_enable lets a high trigger pin set the latch.
// - clock_set_enable lets the divided pulse set the latch.
// - comparator_set_enable lets a high comparator result set the latch.
// - pin_reset_enable lets a high trigger pin reset the latch.
// - clock_reset_enable lets the divided pulse reset the latch.
// - comparator_reset_enable lets a high comparator result reset the latch.
// - Reserved bits 5 and 1 of source enables read 0; software writes 0.
// - cmp_on enables the comparator; clearing it disables it.
// - cmp_invert inverts the presented comparator result.
// - Result readable in comparator control and in the mirror register.
// - Comparator pin driven only with pin enable, output direction and cmp_on.
// - cmp_pin_enable overrides the port latch; cmp_on alone does not.
// - Internal result registered once per instruction cycle; pin path unregistered.
// - cmp_speed_select resets to 1, normal speed; 0 is low power.
// - Reset input dominates when set and reset are both asserted.
// - Latch state undefined after reset; firmware initialises before enabling pins.
`timescale 1ns/100ps
module srl_top
  import srl_pkg::*;
#(
  parameter int DIV_W = SRL_DIV_W,
  parameter int QCLK_DIV = SRL_QCLK_DIV
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic TRIGGER_IN,
  input wire logic CMP_RAW,
  input wire logic PORT_LATCH_CMP,
  output logic CMP_ENABLE,
  output logic CMP_LOW_POWER,
  output logic TRUE_OUT,
  output logic TRUE_OE_N,
  output logic INV_OUT,
  output logic INV_OE_N,
  output logic CMP_PIN_OUT,
  output logic CMP_PIN_OE_N
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_DATA = 2'b10
  } srl_bus_e;

  srl_bus_e bus_q;
  srl_req_s req_q;
  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [7:0] cmp0_q;
  logic [7:0] cmp1_q;
  logic [7:0] pindir_q;
  logic [31:0] rdata_q;
  logic [DIV_W-1:0] div_q;
  logic div_pulse;
  logic [$clog2(QCLK_DIV)-1:0] qphase_q;
  logic qtick;
  logic soft_set_q;
  logic soft_rst_q;
  logic latch_q;
  logic cmp_sync_q;
  logic cmp_live;
  logic wr_ctrl0;
  srl_drive_s drv;

  function automatic logic [7:0] reg_read(input logic [7:0] addr);
    logic [7:0] v;
    v = 8'h00;
    unique case (addr)
      SRL_OFS_CTRL0: v = ctrl0_q & ~((8'h01 << SRL_B_PS) | (8'h01 << SRL_B_PR));
      SRL_OFS_CTRL1: v = ctrl1_q;
      SRL_OFS_CMP0: begin
        v = cmp0_q;
        v[SRL_B_COUT] = cmp_sync_q;
      end
      SRL_OFS_CMP1: v = cmp1_q;
      SRL_OFS_MIRROR: v[SRL_B_MIRROR] = cmp_sync_q;
      SRL_OFS_PINDIR: v = pindir_q;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  function automatic logic addr_phase(input logic sel, input logic [1:0] trans);
    return sel && (trans == SRL_HTRANS_NONSEQ);
  endfunction : addr_phase

  function automatic logic wr_hit(input logic [7:0] ofs);
    return (bus_q == ST_DATA) && req_q.valid && req_q.write && (req_q.addr == ofs);
  endfunction : wr_hit

  // Every pin driver needs its block enable, its own enable and the direction bit at output
  function automatic logic pin_oe_n(input logic en, input logic sel_en, input logic dir_in);
    return ~(en & sel_en & ~dir_in);
  endfunction : pin_oe_n

  // Zero wait states; unmapped addresses read zero and ignore writes
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      req_q <= '0;
    end else if (HREADY) begin
      req_q.valid <= addr_phase(HSEL, HTRANS);
      req_q.write <= HWRITE;
      req_q.addr <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_q <= ST_IDLE;
    end else if (HREADY) begin
      bus_q <= addr_phase(HSEL, HTRANS) ? ST_DATA : ST_IDLE;
    end
  end

  // Read data is captured at the address phase so it stands during the data phase
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (HREADY && addr_phase(HSEL, HTRANS) && !HWRITE) begin
      rdata_q <= {24'h00_0000, reg_read(HADDR[7:0])};
    end
  end

  assign wr_ctrl0 = wr_hit(SRL_OFS_CTRL0);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl0_q <= SRL_RST_CTRL0;
    end else if (wr_ctrl0) begin
      ctrl0_q <= HWDATA[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl1_q <= SRL_RST_CTRL1;
    end else if (wr_hit(SRL_OFS_CTRL1)) begin
      ctrl1_q <= HWDATA[7:0] & SRL_CTRL1_WMASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp0_q <= SRL_RST_CMP0;
    end else if (wr_hit(SRL_OFS_CMP0)) begin
      cmp0_q <= HWDATA[7:0] & SRL_CMP0_WMASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp1_q <= SRL_RST_CMP1;
    end else if (wr_hit(SRL_OFS_CMP1)) begin
      cmp1_q <= HWDATA[7:0] & SRL_CMP1_WMASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pindir_q <= SRL_RST_PINDIR;
    end else if (wr_hit(SRL_OFS_PINDIR)) begin
      pindir_q <= HWDATA[7:0] & SRL_PINDIR_WMASK;
    end
  end

  // Instruction cycle is QCLK_DIV oscillator cycles; qtick marks its end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      qphase_q <= '0;
    end else begin
      qphase_q <= qphase_q + 1'b1;
    end
  end
  assign qtick = (qphase_q == '1);

  // Soft pulses last one oscillator cycle, which is one Q-clock period
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      soft_set_q <= 1'b0;
    end else begin
      soft_set_q <= wr_ctrl0 && HWDATA[SRL_B_PS];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_ctrl0 && HWDATA[SRL_B_PR];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  // Pulse when the low (select+2) bits all read one: once every 2^(select+2) cycles
  assign div_pulse = &(div_q | ~((DIV_W'(1) << (ctrl0_q[SRL_B_DIV_HI:SRL_B_DIV_LO]
                      + SRL_DIV_MIN_LOG2)) - DIV_W'(1)));

  // Comparator: polarity applied unregistered for pin, sampled per instruction cycle
  assign cmp_live = cmp0_q[SRL_B_CON] & (CMP_RAW ^ cmp0_q[SRL_B_CPOL]);
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmp_sync_q <= 1'b0;
    end else if (qtick) begin
      cmp_sync_q <= cmp_live;
    end
  end
  assign CMP_ENABLE = cmp0_q[SRL_B_CON];
  assign CMP_LOW_POWER = ~cmp0_q[SRL_B_CSP];

  always_comb begin
    drv.set = soft_set_q
      | (ctrl1_q[SRL_B_SPE] & TRIGGER_IN)
      | (ctrl1_q[SRL_B_SCKE] & div_pulse)
      | (ctrl1_q[SRL_B_SC1E] & cmp_sync_q);
    drv.rst = soft_rst_q
      | (ctrl1_q[SRL_B_RPE] & TRIGGER_IN)
      | (ctrl1_q[SRL_B_RCKE] & div_pulse)
      | (ctrl1_q[SRL_B_RC1E] & cmp_sync_q);
  end

  // State is zeroed for a clean simulation; firmware must not rely on it
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      latch_q <= 1'b0;
    end else if (ctrl0_q[SRL_B_LEN]) begin
      if (drv.rst) begin
        latch_q <= 1'b0;
      end else if (drv.set) begin
        latch_q <= 1'b1;
      end
    end
  end

  assign TRUE_OUT = latch_q;
  assign INV_OUT = ~latch_q;
  assign TRUE_OE_N = pin_oe_n(ctrl0_q[SRL_B_LEN], ctrl0_q[SRL_B_QEN],
                              pindir_q[SRL_B_DIR_Q]);
  assign INV_OE_N = pin_oe_n(ctrl0_q[SRL_B_LEN], ctrl0_q[SRL_B_NQEN],
                             pindir_q[SRL_B_DIR_NQ]);
  assign CMP_PIN_OUT = cmp0_q[SRL_B_COE] ? cmp_live : PORT_LATCH_CMP;
  assign CMP_PIN_OE_N = pin_oe_n(cmp0_q[SRL_B_COE], cmp0_q[SRL_B_CON],
                                 pindir_q[SRL_B_DIR_CMP]);
endmodule : srl_top

//--- verilog/srl_pkg.sv
// Package: register map, field positions and constants of the SR latch block
package srl_pkg;
  localparam logic [7:0] SRL_OFS_CTRL0 = 8'h00;
  localparam logic [7:0] SRL_OFS_CTRL1 = 8'h04;
  localparam logic [7:0] SRL_OFS_CMP0 = 8'h08;
  localparam logic [7:0] SRL_OFS_CMP1 = 8'h0c;
  localparam logic [7:0] SRL_OFS_MIRROR = 8'h10;
  localparam logic [7:0] SRL_OFS_PINDIR = 8'h14;
  localparam logic [7:0] SRL_RST_CTRL0 = 8'h00;
  localparam logic [7:0] SRL_RST_CTRL1 = 8'h00;
  localparam logic [7:0] SRL_RST_CMP0 = 8'h04;
  localparam logic [7:0] SRL_RST_CMP1 = 8'h00;
  localparam logic [7:0] SRL_RST_PINDIR = 8'h0f;
  localparam logic [7:0] SRL_CTRL1_WMASK = 8'hdd;
  localparam logic [7:0] SRL_CMP0_WMASK = 8'hb7;
  localparam logic [7:0] SRL_CMP1_WMASK = 8'hf1;
  localparam logic [7:0] SRL_PINDIR_WMASK = 8'h0f;
  localparam int SRL_B_LEN = 7;
  localparam int SRL_B_DIV_HI = 6;
  localparam int SRL_B_DIV_LO = 4;
  localparam int SRL_B_QEN = 3;
  localparam int SRL_B_NQEN = 2;
  localparam int SRL_B_PS = 1;
  localparam int SRL_B_PR = 0;
  localparam int SRL_B_SPE = 7;
  localparam int SRL_B_SCKE = 6;
  localparam int SRL_B_SC1E = 4;
  localparam int SRL_B_RPE = 3;
  localparam int SRL_B_RCKE = 2;
  localparam int SRL_B_RC1E = 0;
  localparam int SRL_B_CON = 7;
  localparam int SRL_B_COUT = 6;
  localparam int SRL_B_COE = 5;
  localparam int SRL_B_CPOL = 4;
  localparam int SRL_B_CSP = 2;
  localparam int SRL_B_MIRROR = 0;
  localparam int SRL_B_DIR_Q = 0;
  localparam int SRL_B_DIR_NQ = 1;
  localparam int SRL_B_DIR_CMP = 2;
  localparam int SRL_DIV_W = 9;
  localparam int SRL_DIV_MIN_LOG2 = 2;
  localparam int SRL_QCLK_DIV = 4;
  localparam logic [1:0] SRL_HTRANS_NONSEQ = 2'b10;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } srl_req_s;
  typedef struct packed {
    logic set;
    logic rst;
  } srl_drive_s;
endpackage : srl_pkg

//--- dv/srl_far_model.sv
// Far-side model: trigger pin, comparator decision and port data latch
`timescale 1ns/100ps
module srl_far_model (
  input wire logic clk,
  input wire logic [2:0] lvl,
  output logic trigger_in,
  output logic cmp_raw,
  output logic port_latch
);
  logic [2:0] lvl_q = 3'h0;
  // One edge late on purpose, so the block never sees a source move with the request
  // The comparator decision moves only on a clock edge, as a timer-synchronised one would
  always @(posedge clk) begin
    lvl_q <= lvl;
  end
  assign {trigger_in, cmp_raw, port_latch} = lvl_q;
endmodule : srl_far_model

//--- dv/srl_assertions.sv
// Port checker for the SR latch block
`timescale 1ns/100ps
module srl_checker
  import srl_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic CMP_ENABLE,
  input wire logic CMP_LOW_POWER,
  input wire logic TRUE_OUT,
  input wire logic TRUE_OE_N,
  input wire logic INV_OUT,
  input wire logic INV_OE_N,
  input wire logic CMP_PIN_OE_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic rd;
  assign rd = HSEL && HTRANS == SRL_HTRANS_NONSEQ && !HWRITE && HREADY;
  a_inv_complement: assert property (INV_OUT == !TRUE_OUT)
    else $error("inverted output is not the complement");
  a_cmp_pin_gate: assert property (!CMP_PIN_OE_N |-> CMP_ENABLE)
    else $error("comparator pin driven while comparator off");
  a_speed_default: assert property ($rose(RST_N) |-> !CMP_LOW_POWER)
    else $error("low power mode after reset");
  a_pins_idle: assert property ($rose(RST_N) |-> TRUE_OE_N && INV_OE_N)
    else $error("latch pin driven right after reset");
  a_soft_zero: assert property (rd && HADDR[7:0] == SRL_OFS_CTRL0
    |=> HRDATA[1:0] == 2'h0) else $error("soft pulse bits read back set");
  a_resv_zero: assert property (rd && HADDR[7:0] == SRL_OFS_CTRL1
    |=> !HRDATA[5] && !HRDATA[1]) else $error("reserved bits read back set");
  // Read data must not wander between reads, firmware may sample it late
  a_read_stands: assert property (!rd |=> $stable(HRDATA))
    else $error("read data changed without a read");
  a_ready_okay: assert property (HREADYOUT && !HRESP)
    else $error("slave stalled or answered with error");
  c_true_pin: cover property (!TRUE_OE_N && TRUE_OUT);
  c_inv_pin: cover property (!INV_OE_N && INV_OUT);
  c_cmp_pin: cover property (!CMP_PIN_OE_N);
endmodule : srl_checker
bind srl_top srl_checker u_chk (.CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HREADY,
  .HRDATA, .HREADYOUT, .HRESP, .CMP_ENABLE, .CMP_LOW_POWER, .TRUE_OUT, .TRUE_OE_N,
  .INV_OUT, .INV_OE_N, .CMP_PIN_OE_N);

//--- dv/srl_top_bench.sv
// Self-checking bench for the SR latch block
`timescale 1ns/100ps
module srl_top_bench
  import srl_pkg::*;
;
  logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, rd_q = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] lvl = 3'h0;
  logic hreadyout, hresp, cmp_en, low_pw, t_out, t_oe_n, i_out, i_oe_n, c_out, c_oe_n;
  logic trig, craw, plat;
  logic [31:0] expq[$];
  int miscompares = 0, checked = 0;
  initial forever #25 clk = ~clk;
  srl_top DUT (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .TRIGGER_IN(trig), .CMP_RAW(craw),
    .PORT_LATCH_CMP(plat), .CMP_ENABLE(cmp_en), .CMP_LOW_POWER(low_pw), .TRUE_OUT(t_out),
    .TRUE_OE_N(t_oe_n), .INV_OUT(i_out), .INV_OE_N(i_oe_n), .CMP_PIN_OUT(c_out),
    .CMP_PIN_OE_N(c_oe_n));
  srl_far_model u_far (.clk(clk), .lvl(lvl), .trigger_in(trig), .cmp_raw(craw),
    .port_latch(plat));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= SRL_HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'h1);
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back({24'h0, e});
    bus(1'h0, a, 8'h0);
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : wt
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize
  // Read data is taken at the edge that closes the data phase; upper bits must read 0
  always @(posedge clk) begin
    if (rd_q) begin
      check("read data", hrdata, expq.pop_front());
    end
    rd_q <= hsel && htrans == SRL_HTRANS_NONSEQ && !hwrite;
  end
  initial begin
    #1000000;
    miscompares++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    int n;
    void'($urandom(32'he49b));
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    rd(SRL_OFS_CTRL0, 8'h00);
    rd(SRL_OFS_CMP0, 8'h04);
    rd(SRL_OFS_PINDIR, 8'h0f);
    wr(8'h20, 8'hff);
    rd(8'h20, 8'h00);
    wr(SRL_OFS_CTRL1, 8'hdd);
    rd(SRL_OFS_CTRL1, 8'hdd);
    wr(SRL_OFS_CTRL1, 8'h00);
    wr(SRL_OFS_PINDIR, 8'h00);
    wr(SRL_OFS_CTRL0, 8'h81);
    wr(SRL_OFS_CTRL0, 8'h8e);
    wt(8);
    check("soft set", 32'({t_out, t_oe_n, i_oe_n}), 32'h4);
    rd(SRL_OFS_CTRL0, 8'h8c);
    wr(SRL_OFS_CTRL0, 8'h8d);
    wt(8);
    check("soft reset", 32'({t_out, i_out}), 32'h1);
    wr(SRL_OFS_CTRL1, 8'h80);
    lvl <= 3'h4;
    wt(8);
    check("pin set", 32'(t_out), 32'h1);
    wr(SRL_OFS_CTRL1, 8'h88);
    wt(8);
    check("pin reset wins", 32'(t_out), 32'h0);
    lvl <= 3'h0;
    wr(SRL_OFS_CTRL0, 8'h0c);
    wt(2);
    check("disabled pins", 32'({t_oe_n, i_oe_n}), 32'h3);
    for (int s = 0; s < 8; s++) begin
      wr(SRL_OFS_CTRL1, 8'h00);
      wr(SRL_OFS_CTRL0, {1'h1, s[2:0], 4'h1});
      wt(8);
      wr(SRL_OFS_CTRL1, 8'h40);
      wt((4 << s) + 3);
      check("clock set", 32'(t_out), 32'h1);
      // Pin holds set, divided pulse resets: the latch drops once per divider period
      wr(SRL_OFS_CTRL1, 8'h84);
      lvl <= 3'h4;
      wt(2);
      @(negedge t_out);
      n = 0;
      do begin
        @(posedge clk);
        n++;
        @(negedge clk);
      end while (t_out !== 1'h0);
      check("pulse period", n, 4 << s);
      lvl <= 3'h0;
    end
    wr(SRL_OFS_CTRL1, 8'h44);
    wt(520);
    check("clock reset", 32'(t_out), 32'h0);
    wr(SRL_OFS_CTRL1, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = $urandom;
      lvl <= {1'h0, r[1:0]};
      wr(SRL_OFS_CMP0, {3'h5, r[2], 4'h4});
      wt(10);
      check("cmp pin", 32'({c_oe_n, c_out}), 32'(r[1] ^ r[2]));
      rd(SRL_OFS_CMP0, {1'h1, r[1] ^ r[2], 1'h1, r[2], 4'h4});
      rd(SRL_OFS_MIRROR, {7'h0, r[1] ^ r[2]});
    end
    wr(SRL_OFS_CMP0, 8'h80);
    wt(4);
    check("cmp no pin", 32'({cmp_en, low_pw, c_oe_n, c_out}),
      32'({3'h7, lvl[0]}));
    wr(SRL_OFS_CMP0, 8'h24);
    wt(4);
    check("cmp off", 32'({cmp_en, c_oe_n}), 32'h1);
    wr(SRL_OFS_CMP0, 8'h84);
    lvl <= 3'h2;
    wr(SRL_OFS_CTRL1, 8'h10);
    wt(10);
    check("cmp set", 32'(t_out), 32'h1);
    wr(SRL_OFS_CTRL1, 8'h01);
    wt(10);
    check("cmp reset", 32'(t_out), 32'h0);
    summarize();
  end
endmodule : srl_top_bench
